// ===== core/spi_port_pkg.sv
/*
 * Constants and types for the four-wire serial port: register frame,
 * field positions, reset values and pin bundles.
 * Assumes a 16-bit peripheral bus with word addresses.
 */
package spi_port_pkg;

    // ==========================================================
    // register frame
    localparam logic [15:0] FRAME_BASE = 16'h7040;
    localparam logic [15:0] FRAME_END = 16'h7049;
    localparam logic [3:0] REG_CFG = 4'h0;
    localparam logic [3:0] REG_CTL = 4'h1;
    localparam logic [3:0] REG_STS = 4'h2;
    localparam logic [3:0] REG_PINS = 4'h3;
    localparam logic [3:0] REG_BAUD = 4'h4;
    localparam logic [3:0] REG_RXLO = 4'h5;
    localparam logic [3:0] REG_RXHI = 4'h6;
    localparam logic [3:0] REG_TXLO = 4'h7;
    localparam logic [3:0] REG_TXHI = 4'h8;

    // ==========================================================
    // field positions
    localparam int CFG_POL = 6;
    localparam int CFG_RUN = 7;
    localparam int CTL_RXIE = 0;
    localparam int CTL_TALK = 1;
    localparam int CTL_MASTER = 2;
    localparam int CTL_PHASE = 3;
    localparam int CTL_TXIE = 4;
    localparam int STS_TXF = 5;
    localparam int STS_RXF = 6;
    localparam int STS_OVR = 7;

    // ==========================================================
    // reset values and limits
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [6:0] BAUD_MIN = 7'h03;
    localparam logic [3:0] PINS_RESET = 4'h0;

    // ==========================================================
    // types
    typedef struct packed {
        logic clk;
        logic ste;
        logic simo;
        logic somi;
    } pin4_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } bus_req_type;

    typedef enum logic {ST_IDLE, ST_RUN} xfer_state_type;

endpackage

// ===== core/spi_master_slave_port.sv
/*
 * Four-wire synchronous serial port, master or slave, 1..16 bit words,
 * with nine byte-wide registers on the peripheral bus.
 * Assumes pin inputs are synchronous to clk and pin wires are resolved outside.
 */
`timescale 1ns/10ps
`default_nettype none

module spi_master_slave_port (
    input wire logic clk,
    input wire logic nrst,
    input wire spi_port_pkg::bus_req_type bus_req,
    output logic [15:0] bus_rdata,
    output logic rx_irq,
    output logic tx_irq,
    input wire spi_port_pkg::pin4_type pin_in,
    input wire spi_port_pkg::pin4_type gpio_out,
    input wire spi_port_pkg::pin4_type gpio_dir,
    output var spi_port_pkg::pin4_type pin_out,
    output var spi_port_pkg::pin4_type pin_oe
);
    import spi_port_pkg::*;

    // ==========================================================
    // address decoding
    function automatic logic in_frame(input logic [15:0] a);
        return (a >= FRAME_BASE) && (a < FRAME_END);
    endfunction

    function automatic logic [3:0] reg_index(input logic [15:0] a);
        logic [15:0] off;
        off = a - FRAME_BASE;
        return off[3:0];
    endfunction

    // ==========================================================
    // state
    logic [7:0] cfg_q, cfg_d, ctl_q, ctl_d;
    logic [3:0] pins_q, pins_d;
    logic [6:0] baud_q, baud_d, div_q, div_d;
    logic [15:0] txbuf_q, txbuf_d, rxbuf_q, rxbuf_d;
    logic [15:0] sh_q, sh_d, rx_q, rx_d;
    logic [15:0] rdata_q, rdata_d;
    logic [5:0] edge_q, edge_d, bit_q, bit_d;
    logic rxf_q, rxf_d, ovr_q, ovr_d, txf_q, txf_d;
    logic sclk_q, sclk_d, dout_q, dout_d, sclk_prev_q;
    logic rx_irq_q, rx_irq_d, tx_irq_q, tx_irq_d;
    pin4_type pin_out_q, pin_out_d, pin_oe_q, pin_oe_d;
    xfer_state_type state_q, state_d;

    // derived values
    logic master, pol, phase, talk, running, sel_low, din;
    logic lead, trail, tick, active, wr_hit, rd_hit, pin_edge;
    logic [3:0] widx, ser_out, ser_oe;
    logic [6:0] brr, half_m1;
    logic [7:0] sum8;
    logic [4:0] nbits;
    logic [5:0] last_edge, edge_nx, bit_nx;

    // ==========================================================
    // next-state logic for registers, engine and pins
    always_comb begin
        cfg_d = cfg_q;
        ctl_d = ctl_q;
        pins_d = pins_q;
        baud_d = baud_q;
        txbuf_d = txbuf_q;
        rxbuf_d = rxbuf_q;
        sh_d = sh_q;
        rx_d = rx_q;
        edge_d = edge_q;
        bit_d = bit_q;
        div_d = div_q;
        rxf_d = rxf_q;
        ovr_d = ovr_q;
        txf_d = txf_q;
        sclk_d = sclk_q;
        dout_d = dout_q;
        state_d = state_q;
        rdata_d = WORD_RESET;
        master = ctl_q[CTL_MASTER];
        pol = cfg_q[CFG_POL];
        phase = ctl_q[CTL_PHASE];
        talk = ctl_q[CTL_TALK];
        running = cfg_q[CFG_RUN];
        sel_low = !pin_in.ste;
        din = master ? pin_in.somi : pin_in.simo;
        // divider: period brr+1 core cycles, 125 settings 3..127
        brr = (baud_q < BAUD_MIN) ? BAUD_MIN : baud_q;
        sum8 = {1'b0, brr} + 8'h01;
        half_m1 = sum8[7:1] - 7'h01;
        nbits = {1'b0, cfg_q[3:0]} + 5'h01;
        last_edge = {nbits, 1'b0};
        edge_nx = edge_q + 6'h01;
        bit_nx = bit_q + 6'h01;
        tick = master && (state_q == ST_RUN) && (edge_q != last_edge) && ((div_q == half_m1) || (div_q == brr));
        // data edges come from the pin, so the master samples only once its own edge shows
        pin_edge = (pin_in.clk != sclk_prev_q) && (master ? (state_q == ST_RUN) : sel_low);
        lead = pin_edge && (pin_in.clk != pol);
        trail = pin_edge && (pin_in.clk == pol);
        active = (state_q == ST_RUN) || (!master && (state_q == ST_IDLE));

        // register writes, low byte only
        wr_hit = bus_req.wr && in_frame(bus_req.addr);
        rd_hit = bus_req.rd && in_frame(bus_req.addr);
        widx = reg_index(bus_req.addr);
        if (wr_hit) begin
            case (widx)
                REG_CFG: cfg_d = bus_req.wdata[7:0];
                REG_CTL: ctl_d = bus_req.wdata[7:0];
                REG_PINS: pins_d = bus_req.wdata[3:0];
                REG_BAUD: baud_d = bus_req.wdata[6:0];
                REG_STS: begin
                    if (bus_req.wdata[STS_OVR]) begin
                        ovr_d = 1'b0;
                    end
                end
                REG_TXLO: txbuf_d[7:0] = bus_req.wdata[7:0];
                REG_TXHI: begin
                    txbuf_d[15:8] = bus_req.wdata[7:0];
                    txf_d = 1'b1;
                end
                default: ;
            endcase
        end
        // register reads, upper byte zero
        if (rd_hit) begin
            case (reg_index(bus_req.addr))
                REG_CFG: rdata_d[7:0] = cfg_q;
                REG_CTL: rdata_d[7:0] = ctl_q;
                REG_PINS: rdata_d[3:0] = pins_q;
                REG_BAUD: rdata_d[6:0] = baud_q;
                REG_STS: begin
                    rdata_d[STS_OVR] = ovr_q;
                    rdata_d[STS_RXF] = rxf_q;
                    rdata_d[STS_TXF] = txf_q;
                end
                REG_RXLO: rdata_d[7:0] = rxbuf_q[7:0];
                REG_RXHI: begin
                    rdata_d[7:0] = rxbuf_q[15:8];
                    rxf_d = 1'b0;
                end
                REG_TXLO: rdata_d[7:0] = txbuf_q[7:0];
                REG_TXHI: rdata_d[7:0] = txbuf_q[15:8];
                default: ;
            endcase
        end

        // transfer engine
        case (state_q)
            ST_IDLE: begin
                edge_d = 6'h00;
                bit_d = 6'h00;
                div_d = 7'h00;
                if (master) begin
                    sclk_d = pol;
                end
                if (txf_q) begin // load left-justified word
                    txf_d = wr_hit && (widx == REG_TXHI);
                    sh_d = txbuf_q;
                    if (phase) begin // first bit out half a cycle early
                        dout_d = txbuf_q[15];
                        sh_d = {txbuf_q[14:0], 1'b0};
                    end
                    if (master) begin
                        state_d = ST_RUN;
                    end
                end
            end
            ST_RUN: begin
                if (master) begin
                    div_d = (div_q == brr) ? 7'h00 : div_q + 7'h01;
                    if (tick) begin
                        sclk_d = !sclk_q;
                        edge_d = edge_nx;
                    end
                end
            end
            default: state_d = ST_IDLE;
        endcase

        if (active && (lead || trail)) begin
            bit_d = bit_nx;
            if (state_q == ST_IDLE) begin
                state_d = ST_RUN; // slave starts on its first clock edge, leading or trailing
            end
            if (lead && !phase) begin
                dout_d = sh_q[15];
                sh_d = {sh_q[14:0], 1'b0};
            end
            if (lead == phase) begin // sample edge, MSB first
                rx_d = {rx_q[14:0], din};
            end
            if (trail && phase && (bit_nx != last_edge)) begin
                dout_d = sh_q[15];
                sh_d = {sh_q[14:0], 1'b0};
            end
            if (bit_nx == last_edge) begin // word complete
                state_d = ST_IDLE;
                rxbuf_d = rx_d;
                ovr_d = ovr_d || rxf_q;
                rxf_d = 1'b1; // set wins over a read clear
            end
        end

        // module reset: engine idle, clock at idle level
        if (!running) begin
            state_d = ST_IDLE;
            edge_d = 6'h00;
            bit_d = 6'h00;
            div_d = 7'h00;
            rxf_d = 1'b0;
            ovr_d = 1'b0;
            txf_d = 1'b0;
            sclk_d = pol;
        end

        // interrupt requests
        rx_irq_d = (rxf_d || ovr_d) && ctl_d[CTL_RXIE];
        tx_irq_d = !txf_d && ctl_d[CTL_TXIE] && cfg_d[CFG_RUN];

        // pin roles: master drives clock and simo, slave drives somi
        ser_out = {sclk_q, 1'b1, dout_q, dout_q};
        ser_oe = {master, 1'b0, master && talk, !master && talk && sel_low};
        // general-purpose use of pins not given to the port
        pin_out_d = pin4_type'((pins_q & ser_out) | (~pins_q & gpio_out));
        pin_oe_d = pin4_type'((pins_q & ser_oe) | (~pins_q & gpio_dir));
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cfg_q <= BYTE_RESET;
            ctl_q <= BYTE_RESET;
            pins_q <= PINS_RESET;
            baud_q <= BAUD_MIN;
            txbuf_q <= WORD_RESET;
            rxbuf_q <= WORD_RESET;
            sh_q <= WORD_RESET;
            rx_q <= WORD_RESET;
            rdata_q <= WORD_RESET;
            edge_q <= 6'h00;
            bit_q <= 6'h00;
            div_q <= 7'h00;
            rxf_q <= 1'b0;
            ovr_q <= 1'b0;
            txf_q <= 1'b0;
            sclk_q <= 1'b0;
            dout_q <= 1'b0;
            sclk_prev_q <= 1'b0;
            rx_irq_q <= 1'b0;
            tx_irq_q <= 1'b0;
            pin_out_q <= pin4_type'(PINS_RESET);
            pin_oe_q <= pin4_type'(PINS_RESET);
            state_q <= ST_IDLE;
        end else begin
            cfg_q <= cfg_d;
            ctl_q <= ctl_d;
            pins_q <= pins_d;
            baud_q <= baud_d;
            txbuf_q <= txbuf_d;
            rxbuf_q <= rxbuf_d;
            sh_q <= sh_d;
            rx_q <= rx_d;
            rdata_q <= rdata_d;
            edge_q <= edge_d;
            bit_q <= bit_d;
            div_q <= div_d;
            rxf_q <= rxf_d;
            ovr_q <= ovr_d;
            txf_q <= txf_d;
            sclk_q <= sclk_d;
            dout_q <= dout_d;
            sclk_prev_q <= pin_in.clk;
            rx_irq_q <= rx_irq_d;
            tx_irq_q <= tx_irq_d;
            pin_out_q <= pin_out_d;
            pin_oe_q <= pin_oe_d;
            state_q <= state_d;
        end
    end

    // outputs straight from flip-flops
    assign bus_rdata = rdata_q;
    assign rx_irq = rx_irq_q;
    assign tx_irq = tx_irq_q;
    assign pin_out = pin_out_q;
    assign pin_oe = pin_oe_q;

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_half_period;
        (master && state_q == ST_RUN && sclk_d != sclk_q) |=> (sclk_d == sclk_q);
    endproperty
    a_half_period: assert property (p_half_period) else $error("serial clock half period too short");

    property p_master_clk_oe;
        (master && pins_q[3]) |=> pin_oe_q.clk;
    endproperty
    a_master_clk_oe: assert property (p_master_clk_oe) else $error("master does not drive clock");

    property p_talk_off;
        (!talk && pins_q[1] && pins_q[0]) |=> (!pin_oe_q.simo && !pin_oe_q.somi);
    endproperty
    a_talk_off: assert property (p_talk_off) else $error("data pin driven with transmit off");

    property p_upper_zero;
        bus_req.rd |=> (bus_rdata[15:8] == 8'h00);
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper byte not zero");

    property p_idle_level;
        (master && state_q == ST_IDLE) |=> (sclk_q == $past(pol));
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("clock not at idle level");

    property p_rx_irq;
        (rxf_q && ctl_q[CTL_RXIE]) ##1 (rxf_q && ctl_q[CTL_RXIE]) |-> rx_irq;
    endproperty
    a_rx_irq: assert property (p_rx_irq) else $error("receive interrupt missing");

    property p_tx_write;
        (running && bus_req.wr && bus_req.addr == FRAME_BASE + {12'h000, REG_TXHI}) |=> txf_q;
    endproperty
    a_tx_write: assert property (p_tx_write) else $error("transmit full flag not set");

    property p_drive_lead;
        (running && active && lead && !phase) |=> (dout_q == $past(sh_q[15]));
    endproperty
    a_drive_lead: assert property (p_drive_lead) else $error("bit not driven on leading edge");

    property p_sample_lead;
        (running && active && lead && phase) |=> (rx_q[0] == $past(din));
    endproperty
    a_sample_lead: assert property (p_sample_lead) else $error("bit not sampled on leading edge");

    property p_gpio_oe;
        !pins_q[3] |=> (pin_oe_q.clk == $past(gpio_dir.clk));
    endproperty
    a_gpio_oe: assert property (p_gpio_oe) else $error("gpio direction not applied");

endmodule

`default_nettype wire

// ===== tb/spi_peer_model.sv
/*
 * Behavioural far-side peer for the serial port in master role.
 * Assumes the bench resolves pin wires and pulses load before each word.
 */
`timescale 1ns/10ps
`default_nettype none

module spi_peer_model (
    input wire logic clk,
    input wire logic active,
    input wire logic load,
    input wire logic pol,
    input wire logic phase,
    input wire logic sclk,
    input wire logic simo,
    input wire logic [15:0] tx_word,
    output logic somi,
    output logic [15:0] rx_word
);
    // ============================================================
    // edge tracking and shifting
    logic sclk_q;
    logic [15:0] sh_q;
    logic lead;

    // leading edge leaves the idle level
    assign lead = (sclk_q == pol);

    // drive and sample per the scheme chosen by pol and phase
    always @(posedge clk) begin
        sclk_q <= sclk;
        if (load) begin
            rx_word <= 16'h0000;
            sh_q <= phase ? {tx_word[14:0], 1'b0} : tx_word;
            somi <= phase ? tx_word[15] : ~tx_word[15]; // msb early when phase set, else inverted msb until the first edge
        end else if (active && sclk !== sclk_q) begin
            if (lead != phase) begin
                somi <= sh_q[15]; // launch edge, msb first
                sh_q <= {sh_q[14:0], 1'b0};
            end else begin
                rx_word <= {rx_word[14:0], simo}; // capture edge
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/tb.sv
/*
 * Self-checking bench for the serial port: register access, gpio, master
 * transfers in all schemes, overrun, slave select gating.
 * Assumes the design package and the peer model are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none

module tb;
    import spi_port_pkg::*;
    logic clk, nrst, rx_irq, tx_irq, flip_q, line_ste, peer_on, peer_load, pol, phase, peer_somi, ck_q;
    bus_req_type bus_req;
    logic [15:0] bus_rdata, peer_tx, peer_rx, d;
    pin4_type pin_in, gpio_out, gpio_dir, pin_out, pin_oe;
    int fail_count, tests_run, gap_q, period_q;

    // ============================================================
    // wire resolution: undriven clock and simo lines toggle every cycle, ste follows line_ste, somi the peer when on
    assign pin_in = {pin_oe.clk ? pin_out.clk : flip_q, pin_oe.ste ? pin_out.ste : line_ste,
                     pin_oe.simo ? pin_out.simo : flip_q,
                     pin_oe.somi ? pin_out.somi : (peer_on ? peer_somi : flip_q)};

    spi_master_slave_port u_dut (.clk(clk), .nrst(nrst), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .rx_irq(rx_irq), .tx_irq(tx_irq), .pin_in(pin_in), .gpio_out(gpio_out), .gpio_dir(gpio_dir),
        .pin_out(pin_out), .pin_oe(pin_oe));
    spi_peer_model u_peer (.clk(clk), .active(peer_on), .load(peer_load), .pol(pol), .phase(phase),
        .sclk(pin_in.clk), .simo(pin_in.simo), .tx_word(peer_tx), .somi(peer_somi), .rx_word(peer_rx));

    // clock, float pattern and serial clock period monitor
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        flip_q <= ~flip_q;
        ck_q <= pin_in.clk;
        gap_q <= (pin_in.clk && !ck_q) ? 1 : gap_q + 1;
        if (pin_in.clk && !ck_q) period_q <= gap_q;
    end

    // ============================================================
    // tasks
    task automatic final_report();
        if (fail_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask

    function automatic logic [15:0] at(input logic [3:0] off);
        return FRAME_BASE + {12'h000, off};
    endfunction

    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        @(negedge clk);
        bus_req.wr = 1'b1;
        bus_req.addr = a;
        bus_req.wdata = v;
        @(negedge clk);
        bus_req.wr = 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, output logic [15:0] v);
        @(negedge clk);
        bus_req.rd = 1'b1;
        bus_req.addr = a;
        @(negedge clk);
        bus_req.rd = 1'b0;
        v = bus_rdata;
    endtask

    task automatic wait_sts(input int b);
        logic [15:0] s;
        for (int n = 0; n < 1000; n++) begin
            rd(at(REG_STS), s);
            if (s[b] === 1'b1) return;
        end
        fail_count++;
        $display("wrong value status wait expected set seen clear");
        final_report();
    endtask

    // one master word; peer selected only after both ends are set up
    task automatic xfer(input logic p, input logic h, input logic [4:0] len, input logic [6:0] baud,
                        input logic talk, input logic [15:0] txw, input logic [15:0] ptx);
        logic [15:0] lo, hi, mask;
        logic [4:0] lm1, sh;
        lm1 = len - 5'd1;
        sh = 5'd16 - len;
        mask = 16'hFFFF >> sh;
        peer_on = 1'b0;
        pol = p;
        phase = h;
        wr(at(REG_CFG), {8'h00, 1'b1, p, 2'b00, lm1[3:0]});
        wr(at(REG_CTL), {11'h000, 1'b0, h, 1'b1, talk, 1'b1});
        wr(at(REG_BAUD), {9'h000, baud});
        wr(at(REG_PINS), 16'h000F);
        repeat (2) @(negedge clk);
        chk1("idle clock", p, pin_in.clk);
        chk1("clock enable", 1'b1, pin_oe.clk);
        chk1("simo enable", talk, pin_oe.simo);
        peer_tx = ptx;
        peer_load = 1'b1;
        @(negedge clk);
        peer_load = 1'b0;
        peer_on = 1'b1;
        wr(at(REG_TXLO), {8'h00, txw[7:0]});
        wr(at(REG_TXHI), {8'h00, txw[15:8]});
        wait_sts(STS_RXF);
        chk1("rx irq set", 1'b1, rx_irq);
        rd(at(REG_RXLO), lo);
        rd(at(REG_RXHI), hi);
        chk("received word", (ptx >> sh) & mask, {hi[7:0], lo[7:0]} & mask);
        chk("upper bytes", 16'h0000, {hi[15:8], lo[15:8]});
        if (talk) chk("peer word", (txw >> sh) & mask, peer_rx);
        if (len > 5'd1) chk("bit period", (baud < 7'h03) ? 16'h0004 : {9'h000, baud} + 16'h0001, 16'(period_q));
        rd(at(REG_STS), lo);
        chk1("rx full cleared", 1'b0, lo[STS_RXF]);
        chk1("rx irq clear", 1'b0, rx_irq);
    endtask

    // ============================================================
    // main sequence
    initial begin
        nrst = 1'b0;
        bus_req = '0;
        gpio_out = 4'h0;
        gpio_dir = 4'h0;
        line_ste = 1'b1;
        peer_on = 1'b0;
        peer_load = 1'b0;
        pol = 1'b0;
        phase = 1'b0;
        peer_tx = 16'h0000;
        flip_q = 1'b0;
        gap_q = 0;
        period_q = 0;
        fail_count = 0;
        tests_run = 0;
        repeat (16) @(negedge clk);
        nrst = 1'b1;
        // reset values across the frame, then out-of-frame reads
        for (int i = 0; i < 9; i++) begin
            rd(at(4'(i)), d);
            chk("reset value", (i == 4) ? 16'h0003 : 16'h0000, d);
        end
        rd(FRAME_END, d);
        chk("unmapped", 16'h0000, d);
        rd(FRAME_BASE - 16'h0001, d);
        chk("unmapped", 16'h0000, d);
        wr(at(REG_BAUD), 16'hFF05);
        rd(at(REG_BAUD), d);
        chk("upper byte write", 16'h0005, d);
        // pins in general-purpose function
        gpio_out = 4'hA;
        gpio_dir = 4'h6;
        repeat (2) @(negedge clk);
        chk("gpio pins", 16'h0062, {8'h00, pin_oe, pin_out & 4'h6});
        gpio_dir = 4'h0;
        // all four schemes, lengths 1, 5, 8 and 16, divider bounds, transmit off
        xfer(1'b0, 1'b0, 5'd8, 7'h02, 1'b1, 16'hA500, 16'h3C00);
        xfer(1'b0, 1'b1, 5'd16, 7'h04, 1'b1, 16'h9182, 16'h6E5D);
        xfer(1'b1, 1'b0, 5'd1, 7'h03, 1'b1, 16'h8000, 16'h8000);
        xfer(1'b1, 1'b1, 5'd5, 7'h0A, 1'b1, 16'hB800, 16'h5000);
        xfer(1'b0, 1'b0, 5'd8, 7'h7F, 1'b0, 16'hFF00, 16'hC300);
        // second word without reading the first sets overrun
        wr(at(REG_CTL), 16'h0007);
        repeat (2) begin
            wr(at(REG_TXLO), 16'h0000);
            wr(at(REG_TXHI), 16'h005A);
            wait_sts(STS_RXF);
        end
        wait_sts(STS_OVR);
        wr(at(REG_STS), 16'h0080);
        rd(at(REG_STS), d);
        chk1("overrun cleared", 1'b0, d[STS_OVR]);
        // slave role: outputs gated by select
        peer_on = 1'b0;
        wr(at(REG_CTL), 16'h0002);
        repeat (2) @(negedge clk);
        chk1("slave clock released", 1'b0, pin_oe.clk);
        chk1("slave out idle", 1'b0, pin_oe.somi);
        line_ste = 1'b0;
        repeat (2) @(negedge clk);
        chk1("slave out selected", 1'b1, pin_oe.somi);
        chk1("slave simo released", 1'b0, pin_oe.simo);
        line_ste = 1'b1;
        // transmit interrupt follows its enable while the buffer is empty
        wr(at(REG_CTL), 16'h0010);
        chk1("tx irq set", 1'b1, tx_irq);
        wr(at(REG_CTL), 16'h0000);
        chk1("tx irq clear", 1'b0, tx_irq);
        final_report();
    end
endmodule
`default_nettype wire
